// ### ppc_top.sv
// Phase detector, pump, lock and fast-lock control with APB registers
//
// Function
// RULE1: Delay side select offers no delay, feedback path delayed or reference path delayed.
// RULE2: The reset delay code picks 1.2, 1.9, 2.5 or 3.0 ns of phase detector reset delay.
// RULE3: Software should prefer feedback-path delay with the 1.2 ns code in most setups.
// RULE4: Leakage magnitude is a 5-bit count of 10 uA steps, doubled to 20 uA steps by a control bit.
// RULE5: Leak direction 0 sinks current and 1 sources current.
// RULE6: With down-split enabled each comparison injects a down-split pulse lasting 16 cycles.
// RULE7: With down-split enabled the delay code sets the split level to 0, 1/4, 1/2 or 3/4 of pump current.
// RULE8: A cycle is in lock when up/down edge separation is below a 3-bit threshold from 2 to 16 ns.
// RULE9: Lock is declared after a 3-bit selected count of 4 to 4096 consecutive in-threshold cycles.
// RULE10: A lock output is driven and an invert bit flips its polarity.
// RULE11: A 5-bit pump code sets the nominal current to code plus one times 158 uA.
// RULE12: Software must set the pump supply field to match the actual pump supply.
// RULE13: With fast lock enabled wide-band mode holds for a 13-bit count of comparison cycles; the timer here counts pclk cycles instead.
// RULE14: Cycle-slip logic raises pump current on large frequency error and restores it at lock.
// RULE15: Any out-of-threshold cycle restarts the qualification count and drops lock.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"
module ppc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Phase detector measurements
    input wire logic cmp_tick,
    input wire logic [7:0] edge_sep,
    input wire logic freq_update,
    // Analog controls
    output logic [1:0] delay_side_select,
    output logic [1:0] reset_delay_code,
    output logic [4:0] leak_magnitude,
    output logic leak_step_double,
    output logic leak_direction,
    output logic [9:0] leak_current_ua,
    output logic down_split_pulse,
    output logic [1:0] down_split_level,
    output logic [4:0] pump_current_code,
    output logic [12:0] nominal_pump_current,
    output logic [1:0] pump_supply_select,
    output logic wide_band,
    output logic lock_out
);
    logic [31:0] ctrl_q;
    logic [31:0] lock_q;
    logic [12:0] fast_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] rd_d;
    logic hit_d;
    logic slip_q;
    logic [1:0] side_q;
    logic [1:0] dly_q;
    logic [4:0] leak_q;
    logic leak2x_q;
    logic leakdir_q;
    logic [9:0] leak_ua_q;
    logic split_q;
    logic [1:0] split_lvl_q;
    logic [4:0] pcode_q;
    logic [12:0] pump_ua_q;
    logic [1:0] sup_q;
    logic wide_q;
    logic lock_out_q;
    logic fast_busy;
    logic [12:0] fast_remain;
    logic split_busy;
    logic split_load;
    logic fast_load;
    logic [4:0] pcode_prog;
    logic split_en;
    logic [1:0] dly_code;
    ppc_pkg::ppc_side_t side_sel;

    ppc_lock_if lk ();

    assign lk.cmp_tick = cmp_tick;
    assign lk.edge_sep = edge_sep;
    assign lk.thr_code = lock_q[`PPC_LOCK_THR_LSB +: 3];
    assign lk.cnt_code = lock_q[`PPC_LOCK_CNT_LSB +: 3];

    ppc_lock_det u_lock (
        .pclk(pclk),
        .presetn(presetn),
        .lk(lk.det)
    );

    assign split_en = ctrl_q[`PPC_CTRL_SPLIT];
    assign dly_code = ctrl_q[`PPC_CTRL_DLY_LSB +: 2];
    assign pcode_prog = ctrl_q[`PPC_CTRL_PCODE_LSB +: 5];
    assign split_load = cmp_tick && split_en; // see RULE6
    assign fast_load = freq_update && ctrl_q[`PPC_CTRL_FASTEN]; // see RULE13

    ppc_count_timer #(.W(5)) u_split (
        .pclk(pclk),
        .presetn(presetn),
        .load(split_load),
        .load_val(5'(`PPC_SPLIT_CYCLES)),
        .busy(split_busy),
        .remain()
    );

    ppc_count_timer #(.W(13)) u_fast (
        .pclk(pclk),
        .presetn(presetn),
        .load(fast_load),
        .load_val(fast_q),
        .busy(fast_busy),
        .remain(fast_remain)
    );

    // Register read mux and decode
    always_comb
    begin
        hit_d = 1'b1;
        rd_d = 32'h0000_0000;
        case (paddr)
            `PPC_OFF_CTRL: rd_d = ctrl_q & 32'h003f_ffff;
            `PPC_OFF_LOCK: rd_d = lock_q & 32'h0000_0077;
            `PPC_OFF_FAST: rd_d = {19'h00000, fast_q};
            `PPC_OFF_STAT: rd_d = {16'h0000, fast_remain, slip_q, wide_q, lk.locked};
            default: hit_d = 1'b0;
        endcase
    end

    // APB answer, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !hit_d;
            prdata_q <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    // Configuration writes take effect at the completing access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `PPC_CTRL_RST;
            lock_q <= `PPC_LOCK_RST;
            fast_q <= 13'(`PPC_FAST_RST);
        end
        else if (psel && penable && pready_q && pwrite)
        begin
            if (paddr == `PPC_OFF_CTRL)
                ctrl_q <= pwdata & 32'h003f_ffff;
            if (paddr == `PPC_OFF_LOCK)
                lock_q <= pwdata & 32'h0000_0077;
            if (paddr == `PPC_OFF_FAST)
                fast_q <= pwdata[12:0];
        end
    end

    // Slip boost from large error until lock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            slip_q <= 1'b0;
        else if (!ctrl_q[`PPC_CTRL_SLIPEN] || lk.locked)
            slip_q <= 1'b0; // see RULE14
        else if (lk.large_err)
            slip_q <= 1'b1; // see RULE14
    end

    // Side select, unused code maps to no delay
    always_comb
    begin
        case (ctrl_q[`PPC_CTRL_SIDE_LSB +: 2]) // see RULE1
            2'h1: side_sel = ppc_pkg::PPC_SIDE_FB;
            2'h2: side_sel = ppc_pkg::PPC_SIDE_REF;
            default: side_sel = ppc_pkg::PPC_SIDE_NONE;
        endcase
    end

    // Phase detector delay and down-split controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            side_q <= 2'h0;
            dly_q <= 2'h0;
            split_q <= 1'b0;
            split_lvl_q <= 2'h0;
        end
        else
        begin
            side_q <= side_sel; // see RULE1
            dly_q <= split_en ? 2'h0 : dly_code; // see RULE2
            split_lvl_q <= split_en ? dly_code : 2'h0; // see RULE7
            split_q <= split_en && split_busy; // see RULE6
        end
    end

    // Leakage controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            leak_q <= 5'h00;
            leak2x_q <= 1'b0;
            leakdir_q <= 1'b0;
            leak_ua_q <= 10'h000;
        end
        else
        begin
            leak_q <= ctrl_q[`PPC_CTRL_LEAK_LSB +: 5]; // see RULE4
            leak2x_q <= ctrl_q[`PPC_CTRL_LEAK2X]; // see RULE4
            leakdir_q <= ctrl_q[`PPC_CTRL_LEAKDIR]; // see RULE5
            leak_ua_q <= 10'({5'h00, ctrl_q[`PPC_CTRL_LEAK_LSB +: 5]} * (ctrl_q[`PPC_CTRL_LEAK2X] ?
                10'(`PPC_LEAK_STEP2_UA) : 10'(`PPC_LEAK_STEP_UA))); // see RULE4
        end
    end

    // Pump current, wide-band and slip boosts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pcode_q <= 5'h00;
            pump_ua_q <= 13'(`PPC_PUMP_STEP_UA);
            sup_q <= 2'h0;
            wide_q <= 1'b0;
        end
        else
        begin
            wide_q <= fast_busy && ctrl_q[`PPC_CTRL_FASTEN]; // see RULE13
            pcode_q <= (fast_busy || slip_q) ? `PPC_PUMP_MAX : pcode_prog; // see RULE13 RULE14
            pump_ua_q <= 13'(({8'h00, ((fast_busy || slip_q) ? `PPC_PUMP_MAX : pcode_prog)} + 13'h0001) *
                13'(`PPC_PUMP_STEP_UA)); // see RULE11
            sup_q <= ctrl_q[`PPC_CTRL_SUP_LSB +: 2];
        end
    end

    // Lock output with selectable polarity
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lock_out_q <= 1'b0;
        else
            lock_out_q <= lk.locked ^ ctrl_q[`PPC_CTRL_INV]; // see RULE10
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign delay_side_select = side_q;
    assign reset_delay_code = dly_q;
    assign leak_magnitude = leak_q;
    assign leak_step_double = leak2x_q;
    assign leak_direction = leakdir_q;
    assign leak_current_ua = leak_ua_q;
    assign down_split_pulse = split_q;
    assign down_split_level = split_lvl_q;
    assign pump_current_code = pcode_q;
    assign nominal_pump_current = pump_ua_q;
    assign pump_supply_select = sup_q;
    assign wide_band = wide_q;
    assign lock_out = lock_out_q;

    AST_LOCK_POL: assert property (@(posedge pclk) disable iff (!presetn) // see RULE10
        ##1 lock_out_q == ($past(lk.locked) ^ $past(ctrl_q[`PPC_CTRL_INV]))) else $error("lock polarity wrong");
    AST_SPLIT_LVL: assert property (@(posedge pclk) disable iff (!presetn) // see RULE7
        split_en |=> split_lvl_q == $past(dly_code) && dly_q == 2'h0) else $error("split level wrong");
    AST_BOOST: assert property (@(posedge pclk) disable iff (!presetn) // see RULE14
        slip_q && !lk.locked |=> pcode_q == `PPC_PUMP_MAX) else $error("pump not boosted");
    AST_PUMP_UA: assert property (@(posedge pclk) disable iff (!presetn) // see RULE11
        !fast_busy && !slip_q |=> pump_ua_q == 13'(({8'h00, $past(pcode_prog)} + 13'h0001) * 13'(`PPC_PUMP_STEP_UA)))
        else $error("pump current wrong");

    // Unused side code maps to no delay; delay code passes while split is off
    AST_SIDE: assert property (@(posedge pclk) disable iff (!presetn) // see RULE1
        ctrl_q[`PPC_CTRL_SIDE_LSB +: 2] == 2'h3 |=> side_q == 2'h0) else $error("delay side wrong");
    AST_DLY: assert property (@(posedge pclk) disable iff (!presetn) // see RULE2
        !split_en |=> dly_q == $past(dly_code)) else $error("delay code wrong");
    // Leak sense and split pulse follow their controls
    AST_LEAK_DIR: assert property (@(posedge pclk) disable iff (!presetn) // see RULE5
        1'b1 |=> leakdir_q == $past(ctrl_q[`PPC_CTRL_LEAKDIR])) else $error("leak direction wrong");
    AST_SPLIT_OFF: assert property (@(posedge pclk) disable iff (!presetn) // see RULE6
        !split_en |=> !split_q) else $error("split pulse without enable");
    // Fast lock raises the pump to the boost code
    AST_WIDE: assert property (@(posedge pclk) disable iff (!presetn) // see RULE13
        fast_busy && ctrl_q[`PPC_CTRL_FASTEN] |=> wide_q && pcode_q == `PPC_PUMP_MAX) else $error("wide band missing");
endmodule // ppc_top
`default_nettype wire

// ### ppc_regs.svh
// Register offsets, field positions, reset values and timing figures for the pump control block
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH
`define PPC_OFF_CTRL 12'h000
`define PPC_OFF_LOCK 12'h004
`define PPC_OFF_FAST 12'h008
`define PPC_OFF_STAT 12'h00c
`define PPC_CTRL_SIDE_LSB 0
`define PPC_CTRL_DLY_LSB 2
`define PPC_CTRL_LEAK_LSB 4
`define PPC_CTRL_LEAK2X 9
`define PPC_CTRL_LEAKDIR 10
`define PPC_CTRL_SPLIT 11
`define PPC_CTRL_INV 12
`define PPC_CTRL_PCODE_LSB 13
`define PPC_CTRL_SUP_LSB 18
`define PPC_CTRL_FASTEN 20
`define PPC_CTRL_SLIPEN 21
`define PPC_CTRL_RST 32'h0000_0001
`define PPC_LOCK_THR_LSB 0
`define PPC_LOCK_CNT_LSB 4
`define PPC_LOCK_RST 32'h0000_0000
`define PPC_FAST_RST 32'h0000_0000
`define PPC_DLY0_PS 1200
`define PPC_DLY1_PS 1900
`define PPC_DLY2_PS 2500
`define PPC_DLY3_PS 3000
`define PPC_LEAK_STEP_UA 10
`define PPC_LEAK_STEP2_UA 20
`define PPC_PUMP_STEP_UA 158
`define PPC_SPLIT_CYCLES 16
`define PPC_THR_STEP_PS 2000
`define PPC_SEP_UNIT_PS 100
`define PPC_SLIP_SEP 8'hc8
`define PPC_PUMP_MAX 5'h1f
`endif

// ### ppc_pkg.sv
// Types shared by the pump control modules
package ppc_pkg;
    typedef enum logic [1:0] {PPC_SIDE_NONE, PPC_SIDE_FB, PPC_SIDE_REF} ppc_side_t;
    typedef logic [4:0] ppc_pump_code_t;
endpackage

// ### ppc_lock_if.sv
// Carrier between the top level and the lock detector
`timescale 1ns/1ps
`default_nettype none
interface ppc_lock_if;
    logic cmp_tick;
    logic [7:0] edge_sep;
    logic [2:0] thr_code;
    logic [2:0] cnt_code;
    logic locked;
    logic large_err;
    modport det (input cmp_tick, edge_sep, thr_code, cnt_code, output locked, large_err);
    modport ctl (output cmp_tick, edge_sep, thr_code, cnt_code, input locked, large_err);
endinterface
`default_nettype wire

// ### ppc_count_timer.sv
// Loadable down counter with a busy flag
`timescale 1ns/1ps
`default_nettype none
module ppc_count_timer #(
    parameter int W = 13
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Load
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // State
    output logic busy,
    output logic [W-1:0] remain
);
    generate
        if (W < 2)
        begin : g_chk
            $error("ppc_count_timer: W must be at least 2");
        end
    endgenerate

    logic [W-1:0] cnt_q;
    logic busy_q;

    // Count down one step per clock while busy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (load)
            cnt_q <= load_val;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_q <= 1'b0;
        else if (load)
            busy_q <= (load_val != '0);
        else
            busy_q <= (cnt_q > W'(1));
    end

    assign busy = busy_q;
    assign remain = cnt_q;

    AST_TMR_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // see RULE13
        load && load_val != '0 |=> busy_q && cnt_q == $past(load_val)) else $error("timer load lost");
    AST_TMR_STEP: assert property (@(posedge pclk) disable iff (!presetn) // see RULE6
        !load && cnt_q > W'(1) |=> busy_q && cnt_q == $past(cnt_q) - W'(1)) else $error("timer step wrong");
    AST_TMR_END: assert property (@(posedge pclk) disable iff (!presetn) // see RULE13
        !load && cnt_q <= W'(1) |=> !busy_q) else $error("timer overran");
endmodule // ppc_count_timer
`default_nettype wire

// ### ppc_lock_det.sv
// Lock detector: threshold compare and qualification count
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"
module ppc_lock_det (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Detector side of the carrier
    ppc_lock_if.det lk
);
    logic [12:0] cnt_q;
    logic locked_q;
    logic large_q;
    logic [7:0] thr;
    logic [12:0] target;
    logic below;

    // Threshold of 2 ns times code plus one, in separation units
    always_comb
    begin
        thr = 8'(({5'h00, lk.thr_code} + 8'h01) * (`PPC_THR_STEP_PS / `PPC_SEP_UNIT_PS)); // see RULE8
        below = lk.edge_sep < thr; // see RULE8
        case (lk.cnt_code) // see RULE9
            3'h0: target = 13'h0004;
            3'h1: target = 13'h0008;
            3'h2: target = 13'h0010;
            3'h3: target = 13'h0020;
            3'h4: target = 13'h0040;
            3'h5: target = 13'h0100;
            3'h6: target = 13'h0400;
            default: target = 13'h1000;
        endcase
    end

    // Consecutive in-threshold cycles, restart on any miss
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (lk.cmp_tick)
        begin
            if (!below)
                cnt_q <= '0; // see RULE15
            else if (cnt_q < target)
                cnt_q <= cnt_q + 13'h0001; // see RULE9
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            locked_q <= 1'b0;
        else if (lk.cmp_tick)
            locked_q <= below && (cnt_q + 13'h0001 >= target); // see RULE9 RULE15
    end

    // Large frequency error flag for the slip booster
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            large_q <= 1'b0;
        else if (lk.cmp_tick)
            large_q <= lk.edge_sep >= `PPC_SLIP_SEP; // see RULE14
    end

    assign lk.locked = locked_q;
    assign lk.large_err = large_q;

    sequence s_miss;
        lk.cmp_tick && !below;
    endsequence
    sequence s_hit;
        lk.cmp_tick && below;
    endsequence

    AST_LOCK_DROP: assert property (@(posedge pclk) disable iff (!presetn) // see RULE15
        s_miss |=> !locked_q && cnt_q == '0) else $error("miss did not clear lock");
    AST_LOCK_ROSE: assert property (@(posedge pclk) disable iff (!presetn) // see RULE9
        $rose(locked_q) |-> cnt_q >= $past(target)) else $error("lock declared early");
    AST_LOCK_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // see RULE8
        locked_q && !lk.cmp_tick |=> locked_q) else $error("lock dropped without a tick");
    AST_LOCK_GROW: assert property (@(posedge pclk) disable iff (!presetn) // see RULE9
        s_hit ##0 (cnt_q < target) |=> cnt_q == $past(cnt_q) + 13'h0001) else $error("count not advanced");
endmodule // ppc_lock_det
`default_nettype wire

// ### ppc_pump_model.sv
// Behavioural model of the phase detector and loop that feed the control block
`timescale 1ns/1ps
`default_nettype none
module ppc_pump_model (
    // Clock
    input wire logic pclk,
    // Phase detector side
    output var logic cmp_tick,
    output var logic [7:0] edge_sep,
    output var logic freq_update
);
    initial
    begin
        cmp_tick = 1'b0;
        edge_sep = 8'h5a;
        freq_update = 1'b0;
    end
    // One comparison cycle with the given up/down edge separation
    task automatic tick(input logic [7:0] sep);
        @(posedge pclk);
        cmp_tick <= 1'b1;
        edge_sep <= sep;
        @(posedge pclk);
        cmp_tick <= 1'b0;
        edge_sep <= ~sep;
    endtask
    // New frequency programmed
    task automatic retune();
        @(posedge pclk);
        freq_update <= 1'b1;
        @(posedge pclk);
        freq_update <= 1'b0;
    endtask
endmodule // ppc_pump_model
`default_nettype wire

// ### pll_pfd_lock_and_pump_control_bench.sv
// Self-checking bench for the pump and lock control block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"
module pll_pfd_lock_and_pump_control_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    wire logic cmp_tick, freq_update;
    wire logic [7:0] edge_sep;
    logic [1:0] side, dly, dsl, sup;
    logic [4:0] lmag, pcd;
    logic lx2, ldir, dsp, wb, lock_out, er;
    logic [9:0] lua;
    logic [12:0] nom;
    int error_cnt, n_compared, k, m;
    localparam logic [1:0] SUP = 2'h2; // Matches the pump stage supply

    ppc_top i_ppc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_tick(cmp_tick), .edge_sep(edge_sep), .freq_update(freq_update), .delay_side_select(side),
        .reset_delay_code(dly), .leak_magnitude(lmag), .leak_step_double(lx2), .leak_direction(ldir),
        .leak_current_ua(lua), .down_split_pulse(dsp), .down_split_level(dsl), .pump_current_code(pcd),
        .nominal_pump_current(nom), .pump_supply_select(sup), .wide_band(wb), .lock_out(lock_out));
    ppc_pump_model i_ppc_pump_model (.pclk(pclk), .cmp_tick(cmp_tick), .edge_sep(edge_sep),
        .freq_update(freq_update));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask

    function automatic logic [31:0] ctrl(input logic [1:0] s, d, input logic [4:0] lm, input logic x2, dr, sp,
        iv, input logic [4:0] ic, input logic fe, sl);
        return 32'(s) | (32'(d) << `PPC_CTRL_DLY_LSB) | (32'(lm) << `PPC_CTRL_LEAK_LSB) |
            (32'(x2) << `PPC_CTRL_LEAK2X) | (32'(dr) << `PPC_CTRL_LEAKDIR) | (32'(sp) << `PPC_CTRL_SPLIT) |
            (32'(iv) << `PPC_CTRL_INV) | (32'(ic) << `PPC_CTRL_PCODE_LSB) | (32'(SUP) << `PPC_CTRL_SUP_LSB) |
            (32'(fe) << `PPC_CTRL_FASTEN) | (32'(sl) << `PPC_CTRL_SLIPEN);
    endfunction

    task automatic ticks(input int n, input logic [7:0] s);
        repeat (n) i_ppc_pump_model.tick(s);
        settle();
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        summarize();
    end

    initial
    begin
        error_cnt = 0;
        n_compared = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `PPC_OFF_CTRL, 0);
        chk(rd, `PPC_CTRL_RST);
        apb(0, `PPC_OFF_LOCK, 0);
        chk(rd, `PPC_LOCK_RST);
        apb(0, `PPC_OFF_FAST, 0);
        chk(rd, `PPC_FAST_RST);
        chk(side, 1);
        apb(0, 12'h010, 0);
        chk(er, 1);
        chk(rd, 0);
        $display("test reset and map done");
        for (k = 0; k < 4; k++)
        begin
            apb(1, `PPC_OFF_CTRL, ctrl(k, k, 7 * k + 3, k[0], k[1], 0, 0, 10 * k, 0, 0));
            settle();
            chk(side, (k == 3) ? 0 : k);
            chk(dly, k);
            chk({lx2, lmag, lua}, {k[0], 5'(7 * k + 3), 10'((7 * k + 3) * (k[0] ? 20 : 10))});
            chk(ldir, k[1]);
            chk({pcd, nom}, {5'(10 * k), 13'((10 * k + 1) * `PPC_PUMP_STEP_UA)});
            chk(sup, SUP);
        end
        apb(1, `PPC_OFF_CTRL, ctrl(1, 0, 0, 0, 0, 0, 0, 31, 0, 0));
        settle();
        chk(nom, 32 * `PPC_PUMP_STEP_UA);
        $display("test field decode done");
        for (k = 0; k < 4; k++)
        begin
            apb(1, `PPC_OFF_CTRL, ctrl(1, k, 0, 0, 0, 1, 0, 4, 0, 0));
            settle();
            chk({dsl, dly}, {2'(k), 2'h0});
        end
        i_ppc_pump_model.tick(8'h0a);
        m = 0;
        repeat (40)
        begin
            @(posedge pclk);
            #1;
            m += dsp;
        end
        chk(m, `PPC_SPLIT_CYCLES);
        $display("test down split done");
        apb(1, `PPC_OFF_CTRL, ctrl(1, 0, 0, 0, 0, 0, 0, 4, 0, 0));
        apb(1, `PPC_OFF_LOCK, 0);
        ticks(1, 20);
        ticks(3, 19);
        chk(lock_out, 0);
        ticks(1, 19);
        chk(lock_out, 1);
        ticks(1, 20);
        chk(lock_out, 0);
        apb(1, `PPC_OFF_LOCK, 32'h17);
        ticks(7, 159);
        chk(lock_out, 0);
        ticks(1, 159);
        chk(lock_out, 1);
        apb(1, `PPC_OFF_CTRL, ctrl(1, 0, 0, 0, 0, 0, 1, 4, 0, 0));
        settle();
        chk(lock_out, 0);
        $display("test lock detect done");
        apb(1, `PPC_OFF_FAST, 5);
        apb(1, `PPC_OFF_CTRL, ctrl(1, 0, 0, 0, 0, 0, 0, 4, 1, 0));
        i_ppc_pump_model.retune();
        k = 0;
        m = 0;
        repeat (30)
        begin
            @(posedge pclk);
            #1;
            k += wb;
            m += (pcd === 5'h1f);
        end
        chk({k[15:0], m[15:0]}, {16'h5, 16'h5});
        chk(pcd, 4);
        $display("test fast lock done");
        apb(1, `PPC_OFF_CTRL, ctrl(1, 0, 0, 0, 0, 0, 0, 4, 0, 1));
        apb(1, `PPC_OFF_LOCK, 0);
        ticks(1, 200);
        chk({pcd, nom}, {5'h1f, 13'(32 * `PPC_PUMP_STEP_UA)});
        ticks(4, 10);
        chk({pcd, nom}, {5'h4, 13'(5 * `PPC_PUMP_STEP_UA)});
        $display("test cycle slip done");
        summarize();
    end
endmodule // pll_pfd_lock_and_pump_control_bench
`default_nettype wire
